// *** src/slave_fifo_port.sv ***
// slave fifo port: four endpoint buffers shared by strobe master, usb side and firmware
`timescale 1ns/10ps
`include "sfifo_cfg.svh"

//Contract
//- write strobe pulse stores word, advances pointer
//- first write clears the empty flag
//- select 11 is endpoint 8, 00 endpoint 2
//- read strobe release advances read pointer
//- output enable only drives data bus
//- firmware reaches each fifo through window
//- byte count and fullness flags per fifo
//- endpoint type and direction are programmable
//- size and buffering limits per endpoint
//- reset: endpoints 2,4 bulk out; 6,8 in
//- full speed shrinks non-iso packets to 64
//- level flag asserts at software threshold
//- auto in packetizes without explicit commit
//- auto out passes host packets unhandshaked
//- fifo config bits select auto modes
//- reset leaves every fifo in manual mode
//- auto in length register sets packet size
//- config byte encodes direction, type, size
//- select 01, 10 are endpoints 4, 6; flags
//- chip select high floats bus, ignores strobes
//- packet end commits the current in packet
module slave_fifo_port #(
  parameter int DEPTH = `SF_DEPTH_BYTES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // external master pins
  input  wire sfifo_pkg::pins_in_t  pins_in,
  output sfifo_pkg::pins_out_t      pins_out,
  // usb side
  input  wire logic                 link_full_speed,
  input  wire sfifo_pkg::host_req_t host_req,
  output sfifo_pkg::host_rsp_t      host_rsp,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr
);

  localparam int AW = $clog2(DEPTH);
  typedef logic [`SF_CW-1:0] cnt_t;
  localparam sfifo_pkg::pins_out_t PINS_RST = '{8'h00, 1'b0, 1'b1, 1'b0, 1'b0};

  // configuration state
  logic [7:0]          ep_cfg_q   [4];
  logic [7:0]          ep_cfg_d   [4];
  logic [7:0]          fifo_cfg_q [4];
  logic [7:0]          fifo_cfg_d [4];
  logic [10:0]         autolen_q  [4];
  logic [10:0]         autolen_d  [4];
  cnt_t                thresh_q   [4];
  cnt_t                thresh_d   [4];
  logic [7:0]          revision_control_q;
  logic [7:0]          revision_control_d;
  // buffer state
  logic [7:0]          mem_q      [4][DEPTH];
  cnt_t                count_q    [4];
  cnt_t                count_d    [4];
  cnt_t                commit_q   [4];
  cnt_t                commit_d   [4];
  logic [AW-1:0]       wptr_q     [4];
  logic [AW-1:0]       wptr_d     [4];
  logic [AW-1:0]       rptr_q     [4];
  logic [AW-1:0]       rptr_d     [4];
  logic [3:0]          push;
  logic [3:0]          pop;
  logic [7:0]          push_data  [4];
  // strobe history and registered outputs
  logic                wr_prev_q, wr_prev_d;
  logic                rd_prev_q, rd_prev_d;
  logic                pkt_prev_q, pkt_prev_d;
  sfifo_pkg::pins_out_t pins_q, pins_d;
  sfifo_pkg::host_rsp_t rsp_q, rsp_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                pready_q, pready_d;
  logic                pslverr_q, pslverr_d;
  // helpers
  logic                active, wr_rel, rd_rel, pkt_fire;
  logic                setup, access, win_wr, win_rd, opk_wr, hpop;
  logic [1:0]          sel, hep, opk_ep;
  cnt_t                unc;
  sfifo_pkg::dec_t     dsel;
  logic [3:0]          is_in, full, empty_m, level;
  cnt_t                cap        [4];
  logic [7:0]          head       [4];

  // capacity of one endpoint from its config byte and link speed
  function automatic cnt_t cap_of(input logic [1:0] e, input logic [7:0] c, input logic fs);
    cnt_t       pkt;
    logic [2:0] nb;
    pkt = (c[`SF_EPCFG_SIZE] && !e[0]) ? `SF_PKT_LARGE : `SF_PKT_SMALL;
    if (fs && c[`SF_EPCFG_TYPE_HI:`SF_EPCFG_TYPE_LO] != sfifo_pkg::EP_ISO) begin
      pkt = `SF_PKT_FS;
    end
    case (c[`SF_EPCFG_BUF_HI:`SF_EPCFG_BUF_LO])
      `SF_BUF_X4: nb = 3'h4;
      `SF_BUF_X3: nb = 3'h3;
      default:    nb = 3'h2;
    endcase
    if (e[0]) nb = 3'h2;
    cap_of = cnt_t'(pkt * cnt_t'(nb));
    // buffers deeper than the storage are clipped rather than overrun
    if (cap_of > cnt_t'(DEPTH)) cap_of = cnt_t'(DEPTH);
  endfunction : cap_of

  // apb address decode: global block and one block of registers per endpoint
  function automatic sfifo_pkg::dec_t decode(input logic [11:0] a);
    decode      = '0;
    decode.ep   = a[6:5];
    decode.off  = a[4:0];
    decode.glob = a[11:5] == `SF_GLOB_REGION;
    if (a[1:0] != 2'h0) decode.hit = 1'b0;
    else if (decode.glob) decode.hit = a[4:0] <= `SF_OUT_PKT_END_OFF;
    else decode.hit = a[11:7] == `SF_EP_REGION && a[4:0] <= `SF_WINDOW_OFF;
  endfunction : decode

  // per-endpoint status
  always_comb begin
    for (int e = 0; e < 4; e++) begin
      is_in[e]   = ep_cfg_q[e][`SF_EPCFG_DIR];
      cap[e]     = cap_of(2'(e), ep_cfg_q[e], link_full_speed);
      full[e]    = count_q[e] >= cap[e];
      // the master sees only committed data of an out buffer
      empty_m[e] = is_in[e] ? (count_q[e] == '0) : (commit_q[e] == '0);
      level[e]   = count_q[e] >= thresh_q[e];
      head[e]    = mem_q[e][rptr_q[e]];
    end
  end

  // strobe events; inputs are taken as synchronous, edges come from the last sample
  always_comb begin
    active     = !pins_in.port_chip_select_n;
    sel        = pins_in.fifo_select;
    hep        = host_req.ep;
    wr_rel     = active && !wr_prev_q && pins_in.write_strobe_n;
    rd_rel     = active && !rd_prev_q && pins_in.read_strobe_n;
    pkt_fire   = active && pkt_prev_q && !pins_in.packet_end_n;
    wr_prev_d  = active ? pins_in.write_strobe_n : 1'b1;
    rd_prev_d  = active ? pins_in.read_strobe_n : 1'b1;
    pkt_prev_d = active ? pins_in.packet_end_n : 1'b1;
    setup      = psel && !penable;
    access     = psel && penable && pready_q;
    dsel       = decode(paddr);
    win_wr     = access && pwrite && dsel.hit && !dsel.glob && dsel.off == `SF_WINDOW_OFF;
    win_rd     = access && !pwrite && dsel.hit && !dsel.glob && dsel.off == `SF_WINDOW_OFF;
    opk_wr     = access && pwrite && dsel.hit && dsel.glob && dsel.off == `SF_OUT_PKT_END_OFF &&
                 !pwdata[0] && pwdata[3:1] != 3'h0;
    opk_ep     = pwdata[2:1] - 2'h1;  // 2,4,6,8 map to 0..3
  end

  // buffer next state: one push and one pop per endpoint per cycle
  always_comb begin
    hpop     = 1'b0;
    unc      = '0;
    rsp_d    = '0;
    for (int e = 0; e < 4; e++) begin
      push[e]      = 1'b0;
      pop[e]       = 1'b0;
      push_data[e] = 8'h00;
      if (is_in[e] && wr_rel && sel == 2'(e) && !full[e]) begin
        push[e]      = 1'b1;
        push_data[e] = pins_in.fifo_data_bus;
      end else if (!is_in[e] && host_req.put && hep == 2'(e) && !full[e]) begin
        push[e]      = 1'b1;
        push_data[e] = host_req.data;
      end else if (win_wr && dsel.ep == 2'(e) && !full[e]) begin
        push[e]      = 1'b1;
        push_data[e] = pwdata[7:0];
      end
      // pops reach committed data only, so an empty read never moves a pointer
      if (!is_in[e] && rd_rel && sel == 2'(e) && commit_q[e] != '0) begin
        pop[e] = 1'b1;
      end else if (is_in[e] && host_req.take && hep == 2'(e) && commit_q[e] != '0) begin
        pop[e] = 1'b1;
        hpop   = 1'b1;
      end else if (win_rd && dsel.ep == 2'(e) && commit_q[e] != '0) begin
        pop[e] = 1'b1;
      end
      wptr_d[e]   = wptr_q[e] + AW'(push[e]);
      rptr_d[e]   = rptr_q[e] + AW'(pop[e]);
      count_d[e]  = count_q[e] + cnt_t'(push[e]) - cnt_t'(pop[e]);
      commit_d[e] = commit_q[e] - cnt_t'(pop[e]);
      unc         = count_q[e] - commit_q[e] + cnt_t'(push[e]);
      if (is_in[e] && fifo_cfg_q[e][`SF_FCFG_AUTO_IN] && push[e] && unc >= cnt_t'(autolen_q[e])) begin
        commit_d[e] = count_d[e];
      end
      if (is_in[e] && pkt_fire && sel == 2'(e)) begin
        commit_d[e]    = count_d[e];
        rsp_d.zero_len = unc == '0 && fifo_cfg_q[e][`SF_FCFG_ZERO_LEN];
      end
      if (!is_in[e] && fifo_cfg_q[e][`SF_FCFG_AUTO_OUT] && push[e] && host_req.put && host_req.last) begin
        commit_d[e] = count_d[e];
      end
      if (!is_in[e] && opk_wr && opk_ep == 2'(e)) begin
        commit_d[e] = count_d[e];
      end
      rsp_d.avail[e] = is_in[e] && commit_q[e] != '0;
      rsp_d.space[e] = !is_in[e] && !full[e];
    end
    rsp_d.data  = head[hep];
    rsp_d.valid = hpop;
  end

  // config next state from apb writes, taken in the access phase
  always_comb begin
    ep_cfg_d   = ep_cfg_q;
    fifo_cfg_d = fifo_cfg_q;
    autolen_d  = autolen_q;
    thresh_d   = thresh_q;
    revision_control_d   = revision_control_q;
    if (access && pwrite && dsel.hit) begin
      if (dsel.glob) begin
        if (dsel.off == `SF_REVISION_CONTROL_OFF) revision_control_d = pwdata[7:0];
      end else begin
        case (dsel.off)
          `SF_EPCFG_OFF: begin
            ep_cfg_d[dsel.ep] = pwdata[7:0];
            if (dsel.ep[0]) begin  // endpoints 4 and 8: 512 bytes, double only
              ep_cfg_d[dsel.ep][`SF_EPCFG_SIZE] = 1'b0;
              ep_cfg_d[dsel.ep][`SF_EPCFG_BUF_HI:`SF_EPCFG_BUF_LO] = `SF_BUF_X2;
            end
          end
          `SF_FIFOCFG_OFF: fifo_cfg_d[dsel.ep] = pwdata[7:0];
          `SF_AUTOLEN_OFF: autolen_d[dsel.ep]  = pwdata[10:0];
          `SF_THRESH_OFF:  thresh_d[dsel.ep]   = pwdata[`SF_CW-1:0];
          default: ;
        endcase
      end
    end
  end

  // read data and error are prepared in the setup cycle; zero wait states
  always_comb begin
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (setup) begin
      pslverr_d = !dsel.hit;
      if (dsel.hit && dsel.glob) begin
        if (dsel.off == `SF_REVISION_CONTROL_OFF) prdata_d = {24'h000000, revision_control_q};
      end else if (dsel.hit) begin
        // a window read shows the head now; a strobe pop before access may move it
        case (dsel.off)
          `SF_EPCFG_OFF:   prdata_d = {24'h000000, ep_cfg_q[dsel.ep]};
          `SF_FIFOCFG_OFF: prdata_d = {24'h000000, fifo_cfg_q[dsel.ep]};
          `SF_AUTOLEN_OFF: prdata_d = {21'h000000, autolen_q[dsel.ep]};
          `SF_THRESH_OFF:  prdata_d = {19'h00000, thresh_q[dsel.ep]};
          `SF_BYTECNT_OFF: prdata_d = {19'h00000, count_q[dsel.ep]};
          `SF_FLAGS_OFF:   prdata_d = {29'h0, level[dsel.ep], empty_m[dsel.ep], full[dsel.ep]};
          `SF_WINDOW_OFF:  prdata_d = {24'h000000, head[dsel.ep]};
          default:         prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // pin outputs except the bus enable follow the selected fifo
  always_comb begin
    pins_d.fifo_data_bus           = head[sel];
    pins_d.fifo_data_bus_oe        = active && !pins_in.bus_output_enable_n;
    pins_d.flag_full_n             = !full[sel];
    pins_d.flag_pin_c_n            = !empty_m[sel];
    pins_d.programmable_level_flag = level[sel];
  end

  // config registers; hard reset gives bulk endpoints in manual mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_cfg_q[0] <= `SF_EP2CFG_RST;
      ep_cfg_q[1] <= `SF_EP4CFG_RST;
      ep_cfg_q[2] <= `SF_EP6CFG_RST;
      ep_cfg_q[3] <= `SF_EP8CFG_RST;
      for (int e = 0; e < 4; e++) begin
        fifo_cfg_q[e] <= `SF_FIFOCFG_RST;
        autolen_q[e]  <= `SF_AUTOLEN_RST;
        thresh_q[e]   <= `SF_THRESH_RST;
      end
      revision_control_q <= `SF_REVISION_CONTROL_RST;
    end else begin
      ep_cfg_q   <= ep_cfg_d;
      fifo_cfg_q <= fifo_cfg_d;
      autolen_q  <= autolen_d;
      thresh_q   <= thresh_d;
      revision_control_q   <= revision_control_d;
    end
  end

  // buffer pointers, counts and strobe history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < 4; e++) begin
        count_q[e]  <= '0;
        commit_q[e] <= '0;
        wptr_q[e]   <= '0;
        rptr_q[e]   <= '0;
      end
      wr_prev_q  <= 1'b1;
      rd_prev_q  <= 1'b1;
      pkt_prev_q <= 1'b1;
    end else begin
      count_q    <= count_d;
      commit_q   <= commit_d;
      wptr_q     <= wptr_d;
      rptr_q     <= rptr_d;
      wr_prev_q  <= wr_prev_d;
      rd_prev_q  <= rd_prev_d;
      pkt_prev_q <= pkt_prev_d;
    end
  end

  // storage carries no reset: bus and window show the head byte whether committed or not
  always_ff @(posedge clk) begin
    for (int e = 0; e < 4; e++) begin
      if (push[e]) mem_q[e][wptr_q[e]] <= push_data[e];
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_q    <= PINS_RST;
      rsp_q     <= '0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pins_q    <= pins_d;
      rsp_q     <= rsp_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pins_out = pins_q;
  assign host_rsp = rsp_q;
  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ep8_write_a: assert property ((wr_rel && sel == 2'h3 && is_in[3] && !full[3])
    |=> wptr_q[3] == AW'($past(wptr_q[3]) + 1'b1) && count_q[3] != '0) else $error("ep8 write lost");
  empty_clear_a: assert property ((push[3] && is_in[3]) |=> !empty_m[3])
    else $error("empty flag stuck after write");
  flag_route_a: assert property (##1 pins_out.flag_pin_c_n == !$past(empty_m[pins_in.fifo_select]))
    else $error("flags not from selected fifo");
  read_pop_a: assert property ((rd_rel && sel == 2'h0 && !is_in[0] && commit_q[0] != '0)
    |=> rptr_q[0] == AW'($past(rptr_q[0]) + 1'b1)) else $error("read release did not advance");
  oe_only_a: assert property (##1 pins_out.fifo_data_bus_oe ==
    $past(!pins_in.port_chip_select_n && !pins_in.bus_output_enable_n)) else $error("bus enable wrong");
  cs_ignore_a: assert property ((pins_in.port_chip_select_n && !psel && !host_req.put)
    |=> $stable(wptr_q[3]) && $stable(rptr_q[0])) else $error("strobe seen while deselected");
  full_ignore_a: assert property ((wr_rel && sel == 2'h3 && full[3]) |=> $stable(wptr_q[3]))
    else $error("write into full fifo");
  level_pin_a: assert property ((sel == 2'h1 && count_q[1] >= thresh_q[1])
    |=> pins_out.programmable_level_flag) else $error("level flag missing");
  auto_in_a: assert property ((push[2] && is_in[2] && fifo_cfg_q[2][`SF_FCFG_AUTO_IN] &&
    count_q[2] - commit_q[2] + 1'b1 >= cnt_t'(autolen_q[2])) |=> commit_q[2] == count_q[2])
    else $error("auto in packet not committed");
  pkt_end_a: assert property ((pkt_fire && sel == 2'h3 && is_in[3]) |=> commit_q[3] == count_q[3])
    else $error("packet end did not commit");
  fs_size_a: assert property (link_full_speed &&
    ep_cfg_q[1][`SF_EPCFG_TYPE_HI:`SF_EPCFG_TYPE_LO] != sfifo_pkg::EP_ISO |-> cap[1] == 13'h0080)
    else $error("full speed size not 64");
  apb_answer_a: assert property (setup |=> pready ##1 !pready) else $error("apb answer timing");

endmodule : slave_fifo_port

// *** src/sfifo_cfg.svh ***
// offsets, field positions, reset values and sizes of the slave fifo port
`ifndef SFIFO_CFG_SVH
`define SFIFO_CFG_SVH

`define SF_DEPTH_BYTES     4096
`define SF_CW              13

`define SF_GLOB_REGION     7'h00
`define SF_EP_REGION       5'h02
`define SF_REVISION_CONTROL_OFF      5'h00
`define SF_OUT_PKT_END_OFF 5'h04
`define SF_EPCFG_OFF       5'h00
`define SF_FIFOCFG_OFF     5'h04
`define SF_AUTOLEN_OFF     5'h08
`define SF_THRESH_OFF      5'h0c
`define SF_BYTECNT_OFF     5'h10
`define SF_FLAGS_OFF       5'h14
`define SF_WINDOW_OFF      5'h18

`define SF_EPCFG_DIR       6
`define SF_EPCFG_TYPE_HI   5
`define SF_EPCFG_TYPE_LO   4
`define SF_EPCFG_SIZE      3
`define SF_EPCFG_BUF_HI    1
`define SF_EPCFG_BUF_LO    0
`define SF_BUF_X4          2'h0
`define SF_BUF_X2          2'h2
`define SF_BUF_X3          2'h3
`define SF_FCFG_AUTO_OUT   4
`define SF_FCFG_AUTO_IN    3
`define SF_FCFG_ZERO_LEN   2

`define SF_EP2CFG_RST      8'ha2
`define SF_EP4CFG_RST      8'ha2
`define SF_EP6CFG_RST      8'he2
`define SF_EP8CFG_RST      8'he2
`define SF_FIFOCFG_RST     8'h00
`define SF_AUTOLEN_RST     11'h200
`define SF_THRESH_RST      13'h0000
`define SF_REVISION_CONTROL_RST      8'h00

`define SF_PKT_SMALL       13'h0200
`define SF_PKT_LARGE       13'h0400
`define SF_PKT_FS          13'h0040

`endif

// *** src/sfifo_pkg.sv ***
// types shared by the slave fifo port
package sfifo_pkg;

  typedef enum logic [1:0] {
    EP_ISO  = 2'h1,
    EP_BULK = 2'h2,
    EP_INT  = 2'h3
  } ep_type_t;

  typedef struct packed {
    logic       port_chip_select_n;
    logic [1:0] fifo_select;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       bus_output_enable_n;
    logic       packet_end_n;
    logic [7:0] fifo_data_bus;
  } pins_in_t;

  typedef struct packed {
    logic [7:0] fifo_data_bus;
    logic       fifo_data_bus_oe;
    logic       flag_full_n;
    logic       flag_pin_c_n;
    logic       programmable_level_flag;
  } pins_out_t;

  typedef struct packed {
    logic       take;
    logic       put;
    logic       last;
    logic [1:0] ep;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       zero_len;
    logic [3:0] avail;
    logic [3:0] space;
  } host_rsp_t;

  typedef struct packed {
    logic       hit;
    logic       glob;
    logic [1:0] ep;
    logic [4:0] off;
  } dec_t;

endpackage : sfifo_pkg

// *** bench/strobe_master.sv ***
// strobe master model standing in for the external parallel bus master
`timescale 1ns/10ps
module strobe_master (
  // clock
  input  wire logic                 clk,
  // device pins
  input  wire sfifo_pkg::pins_out_t pins_out,
  output sfifo_pkg::pins_in_t       pins
);
  // chip selected, every strobe released, bus parked at 0
  initial begin
    pins = 15'h0f00;
  end

  // select, wait for room, then pulse the write strobe
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk) pins.fifo_select <= sel;
    repeat (2) @(posedge clk);
    while (pins_out.flag_full_n === 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    pins.fifo_data_bus <= d;
    pins.write_strobe_n <= 1'b0;
    @(posedge clk) pins.write_strobe_n <= 1'b1;
    // data held through the release edge, then no longer shown
    @(posedge clk) pins.fifo_data_bus <= ~d;
  endtask : wr

  // insist skips the empty wait, so a refused read can be provoked
  task automatic rd(input logic [1:0] sel, input bit insist, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk) pins.fifo_select <= sel;
    repeat (2) @(posedge clk);
    while (!insist && pins_out.flag_pin_c_n === 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    pins.bus_output_enable_n <= 1'b0;
    @(posedge clk) pins.read_strobe_n <= 1'b0;
    @(posedge clk) d = pins_out.fifo_data_bus;
    pins.read_strobe_n <= 1'b1;
    @(posedge clk) pins.bus_output_enable_n <= 1'b1;
  endtask : rd

  // packet end pulse
  task automatic pkt_end();
    @(posedge clk) pins.packet_end_n <= 1'b0;
    @(posedge clk) pins.packet_end_n <= 1'b1;
  endtask : pkt_end

  // level controls
  task automatic set_cs(input logic v);
    @(posedge clk) pins.port_chip_select_n <= v;
  endtask : set_cs

  task automatic set_oe(input logic v);
    @(posedge clk) pins.bus_output_enable_n <= v;
  endtask : set_oe
endmodule : strobe_master

// *** bench/slave_fifo_port_test.sv ***
// self-checking testbench of the slave fifo port
`timescale 1ns/10ps
module slave_fifo_port_test;
  logic                 clk;
  logic                 rst_n;
  sfifo_pkg::pins_in_t  pins_in;
  sfifo_pkg::pins_out_t pins_out;
  sfifo_pkg::host_req_t host_req;
  sfifo_pkg::host_rsp_t host_rsp;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [31:0]          rdata;
  logic                 err;
  logic [7:0]           d;
  logic                 fs;
  int                   fails;
  int                   checks_done;

  // small depth keeps the buffers short, yet above the full speed double buffer of 128
  slave_fifo_port #(.DEPTH(256)) slave_fifo_port_i (
    .clk(clk), .rst_n(rst_n), .pins_in(pins_in), .pins_out(pins_out),
    .link_full_speed(fs), .host_req(host_req), .host_rsp(host_rsp),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  strobe_master strobe_master_i (.clk(clk), .pins_out(pins_out), .pins(pins_in));

  // 200 mhz
  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready however long it takes, the watchdog bounds it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] ea(input logic [1:0] e, input logic [11:0] off);
    return 12'h100 + {5'h0, e, 5'h00} + off;
  endfunction : ea

  // flags are registered one edge after the push lands
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic host_take(input logic [1:0] ep, input logic [7:0] exp);
    @(posedge clk);
    host_req.take <= 1'b1;
    host_req.ep <= ep;
    @(posedge clk) host_req.take <= 1'b0;
    #1;
    chk({23'h0, host_rsp.valid, host_rsp.data}, {24'h1, exp});
  endtask : host_take

  task automatic host_put(input logic [1:0] ep, input logic [7:0] v);
    @(posedge clk);
    host_req.put <= 1'b1;
    host_req.ep <= ep;
    host_req.data <= v;
    @(posedge clk) host_req.put <= 1'b0;
  endtask : host_put

  task automatic t_reset();
    logic [31:0] cfg [4] = '{32'ha2, 32'ha2, 32'he2, 32'he2};
    for (int e = 0; e < 4; e++) begin
      apb(1'b0, ea(2'(e), 12'h000), 32'h0);
      chk(rdata, cfg[e]);
      apb(1'b0, ea(2'(e), 12'h004), 32'h0);
      chk(rdata, 32'h0);
      apb(1'b0, ea(2'(e), 12'h008), 32'h0);
      chk(rdata, 32'h200);
    end
    apb(1'b1, 12'h000, 32'h03);
    apb(1'b1, ea(2'h0, 12'h000), 32'hbb);
    apb(1'b0, ea(2'h0, 12'h000), 32'h0);
    chk(rdata, 32'hbb);
    apb(1'b1, ea(2'h0, 12'h000), 32'ha2);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write_in();
    strobe_master_i.wr(2'h3, 8'h11);
    settle();
    chk({31'h0, pins_out.flag_pin_c_n}, 32'h1);
    strobe_master_i.wr(2'h3, 8'h22);
    strobe_master_i.wr(2'h3, 8'h33);
    apb(1'b0, ea(2'h3, 12'h010), 32'h0);
    chk(rdata, 32'h3);
    chk({31'h0, host_rsp.avail[3]}, 32'h0);
    strobe_master_i.pkt_end();
    settle();
    chk({31'h0, host_rsp.avail[3]}, 32'h1);
    host_take(2'h3, 8'h11);
    host_take(2'h3, 8'h22);
    host_take(2'h3, 8'h33);
    $display("test write in done");
  endtask : t_write_in

  task automatic t_read_out();
    host_put(2'h0, 8'h5a);
    host_put(2'h0, 8'ha5);
    apb(1'b1, 12'h004, 32'h82);
    strobe_master_i.rd(2'h0, 1'b0, d);
    chk({24'h0, d}, 32'h5a);
    strobe_master_i.rd(2'h0, 1'b0, d);
    chk({24'h0, d}, 32'ha5);
    settle();
    chk({31'h0, pins_out.flag_pin_c_n}, 32'h0);
    strobe_master_i.rd(2'h0, 1'b1, d);
    host_put(2'h0, 8'hc3);
    apb(1'b1, 12'h004, 32'h82);
    strobe_master_i.rd(2'h0, 1'b0, d);
    chk({24'h0, d}, 32'hc3);
    $display("test read out done");
  endtask : t_read_out

  task automatic t_cs();
    strobe_master_i.set_cs(1'b1);
    strobe_master_i.set_oe(1'b0);
    strobe_master_i.wr(2'h2, 8'h77);
    settle();
    chk({31'h0, pins_out.fifo_data_bus_oe}, 32'h0);
    apb(1'b0, ea(2'h2, 12'h010), 32'h0);
    chk(rdata, 32'h0);
    strobe_master_i.set_cs(1'b0);
    settle();
    chk({31'h0, pins_out.fifo_data_bus_oe}, 32'h1);
    apb(1'b0, ea(2'h2, 12'h010), 32'h0);
    chk(rdata, 32'h0);
    strobe_master_i.set_oe(1'b1);
    $display("test chip select done");
  endtask : t_cs

  task automatic t_auto_in();
    apb(1'b1, ea(2'h2, 12'h004), 32'h0c);
    apb(1'b1, ea(2'h2, 12'h008), 32'h2);
    apb(1'b1, ea(2'h2, 12'h00c), 32'h2);
    strobe_master_i.wr(2'h2, 8'h41);
    settle();
    chk({30'h0, pins_out.programmable_level_flag, host_rsp.avail[2]}, 32'h0);
    strobe_master_i.wr(2'h2, 8'h42);
    settle();
    chk({30'h0, pins_out.programmable_level_flag, host_rsp.avail[2]}, 32'h3);
    host_take(2'h2, 8'h41);
    host_take(2'h2, 8'h42);
    // nothing left uncommitted: the pulse announces a zero length packet
    strobe_master_i.pkt_end();
    #1;
    chk({31'h0, host_rsp.zero_len}, 32'h1);
    $display("test auto in done");
  endtask : t_auto_in

  task automatic t_auto_out();
    apb(1'b1, ea(2'h1, 12'h004), 32'h10);
    apb(1'b1, ea(2'h1, 12'h018), 32'h60);
    host_req.last <= 1'b1;
    host_put(2'h1, 8'h61);
    settle();
    chk({31'h0, host_rsp.space[1]}, 32'h1);
    apb(1'b0, ea(2'h1, 12'h014), 32'h0);
    chk(rdata, 32'h4);
    apb(1'b0, ea(2'h1, 12'h018), 32'h0);
    chk(rdata, 32'h60);
    apb(1'b0, ea(2'h1, 12'h018), 32'h0);
    chk(rdata, 32'h61);
    $display("test auto out done");
  endtask : t_auto_out

  // full speed caps the in buffer at 128; the last window write and the strobe are refused
  task automatic t_full();
    fs <= 1'b1;
    for (int i = 0; i < 129; i++) begin
      apb(1'b1, ea(2'h3, 12'h018), 32'(i));
    end
    apb(1'b0, ea(2'h3, 12'h014), 32'h0);
    chk(rdata, 32'h5);
    strobe_master_i.wr(2'h3, 8'hee);
    chk({31'h0, pins_out.flag_full_n}, 32'h0);
    apb(1'b0, ea(2'h3, 12'h010), 32'h0);
    chk(rdata, 32'h80);
    $display("test full speed done");
  endtask : t_full

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    host_req = '0;
    fs = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_write_in();
    t_read_out();
    t_cs();
    t_auto_in();
    t_auto_out();
    t_full();
    finish_test();
  end

  // watchdog: tests need well under 2000 cycles
  initial begin
    #(20000 * 5);
    fails++;
    finish_test();
  end
endmodule : slave_fifo_port_test
